// ===== rtl/psr_pkg.sv
// Package for the page-select and identification register bank
package psr_pkg;
    // Byte offsets within a page
    localparam logic [7:0] OFS_SIL_REV = 8'h00;
    localparam logic [7:0] OFS_PAGE = 8'h01;
    localparam logic [7:0] OFS_PN_LO = 8'h02;
    localparam logic [7:0] OFS_PN_HI = 8'h03;
    localparam logic [7:0] OFS_GRADE = 8'h04;
    localparam logic [7:0] OFS_DEV_REV = 8'h05;
    // Full addresses of page-zero control bytes
    localparam logic [15:0] ADDR_CTRL = 16'h001E;
    localparam logic [15:0] ADDR_OUT_EN = 16'h0020;
    localparam logic [15:0] ADDR_IO_CFG = 16'h0021;
    localparam logic [15:0] ADDR_BURN = 16'h0022;
    // Bit positions and field width
    localparam int BIT_PDN = 0;
    localparam int BIT_HARD_RST = 1;
    localparam int BIT_BURN = 0;
    localparam int BIT_IO_1V8 = 0;
    localparam int BIT_REF_EXT_OSC = 1;
    localparam int SIL_REV_W = 4;
    // Reset and blank-part values and read latency
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] BLANK_OUT_EN = 8'h00;
    localparam logic [7:0] BLANK_IO_CFG = 8'h03;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [1:0] RD_LATENCY = 2'h2;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] offset;
        logic [7:0] wdata;
    } psr_req_type;

    typedef struct packed {
        logic [7:0] out_en;
        logic io_1v8;
        logic ref_ext_osc;
        logic powerdown;
    } psr_cfg_type;

    typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_BURN} psr_state_type;
endpackage : psr_pkg

// ===== rtl/psr_mem.sv
// Volatile configuration byte store with registered read data
module psr_mem #(
    parameter int AW = 10,
    parameter int DW = 8
) (
    input wire logic i_mclk,              // System clock
    input wire logic i_we,                // Write strobe
    input wire logic [AW-1:0] i_waddr,    // Write address
    input wire logic [DW-1:0] i_wdata,    // Write data
    input wire logic [AW-1:0] i_raddr,    // Read address
    output logic [DW-1:0] o_rdata         // Read data, one cycle after address
);
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge i_mclk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule : psr_mem

// ===== rtl/psr_regs.sv
// Page-select, identification and hard-reset register bank
//
// Contract
// - Hard reset bit or low reset pin restarts the device and ends with an output alignment pulse.
// - A hard reset reloads the whole byte store from non-volatile memory, dropping unsaved writes; page and powerdown reset to 0.
// - The page-select register answers at offset 0x01 on every page.
// - Reading the page-select register returns the active page.
// - Writing the page-select register sets the active page, any of 256, reset to page 0.
// - A read-only 4-bit silicon revision sits in bits 3:0 of address 0x0000.
// - A read-only 16-bit base part number sits low byte at 0x0002, high byte at 0x0003.
// - The read-only speed-grade byte at 0x0004 holds the grade letter as an index from A.
// - The read-only device revision byte at 0x0005 holds the revision letter as an index.
// - A blank part comes up with every output clock disabled.
// - A blank part defaults to 1.8 V host I/O and the external reference oscillator.
// - A programmed part loads its whole configuration from non-volatile memory at power-up.
// - Registers are writable whenever no load or burn is running, and a burn copies them into non-volatile memory.
// - The powerdown bit gates the outputs while the host port and registers keep working.
module psr_regs #(
    parameter int MEM_AW = 10,
    parameter logic [3:0] SIL_REV = 4'h5,          // Arbitrary value
    parameter logic [15:0] PART_NUM = 16'hA5C3,    // Arbitrary value
    parameter logic [7:0] GRADE = 8'h02,           // Arbitrary value
    parameter logic [7:0] DEV_REV = 8'h03          // Arbitrary value
) (
    input wire logic i_mclk,                        // System clock, 50 MHz
    input wire logic i_rst,                         // Power-on reset, sync, high
    input wire logic i_hard_reset_pin_n,            // Hard reset pin, low active
    input wire psr_pkg::psr_req_type i_req,         // Host byte access
    output logic [7:0] o_rdata,                     // Read data
    output logic o_rvalid,                          // Read data valid pulse
    output logic o_busy,                            // Load or burn running
    input wire logic i_nvm_blank,                   // Non-volatile store unprogrammed
    output logic [MEM_AW-1:0] o_nvm_addr,           // Non-volatile store address
    input wire logic [7:0] i_nvm_data,              // Non-volatile read data
    output logic o_nvm_we,                          // Non-volatile write pulse
    output logic [7:0] o_nvm_wdata,                 // Non-volatile write data
    output psr_pkg::psr_cfg_type o_cfg,             // Active configuration
    output logic [7:0] o_out_clk_en,                // Output clock enables
    output logic o_align_pulse                      // Outputs restart aligned
);
    localparam logic [MEM_AW-1:0] CNT_LAST = '1;

    psr_pkg::psr_state_type state_reg, state_next;
    logic [7:0] page_reg, page_next;
    logic pdn_reg, pdn_next;
    logic [7:0] out_en_reg, out_en_next;
    logic [7:0] io_cfg_reg, io_cfg_next;
    logic [MEM_AW-1:0] cnt_reg, cnt_next;
    logic pipe_vld_reg, pipe_vld_next;
    logic [MEM_AW-1:0] pipe_addr_reg, pipe_addr_next;
    logic align_reg, align_next;
    logic [1:0] rd_pipe_reg, rd_pipe_next;
    logic [7:0] rd_const_reg, rd_const_next;
    logic rd_use_mem_reg, rd_use_mem_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [15:0] addr;
    logic mem_we;
    logic [MEM_AW-1:0] mem_waddr, mem_raddr;
    logic [7:0] mem_wdata, mem_rdata, load_byte;
    logic host_wr, host_rd, hard_rst_req;

    function automatic logic [7:0] blank_default(input logic [15:0] a);
        if (a == psr_pkg::ADDR_OUT_EN) begin
            return psr_pkg::BLANK_OUT_EN;
        end else if (a == psr_pkg::ADDR_IO_CFG) begin
            return psr_pkg::BLANK_IO_CFG;
        end
        return psr_pkg::BYTE_ZERO;
    endfunction : blank_default

    function automatic logic [15:0] full_addr(input logic [MEM_AW-1:0] a);
        return 16'(a);
    endfunction : full_addr

    assign addr = {page_reg, i_req.offset};
    assign host_wr = i_req.wr && (state_reg == psr_pkg::ST_RUN);
    assign host_rd = i_req.rd && !i_req.wr && (state_reg == psr_pkg::ST_RUN);
    assign hard_rst_req = !i_hard_reset_pin_n ||
        (host_wr && addr == psr_pkg::ADDR_CTRL && i_req.wdata[psr_pkg::BIT_HARD_RST]);
    // A blank store reads as the built-in defaults
    assign load_byte = i_nvm_blank ? blank_default(full_addr(pipe_addr_reg)) : i_nvm_data;

    // Store write and read port steering
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = addr[MEM_AW-1:0];
        mem_wdata = i_req.wdata;
        mem_raddr = addr[MEM_AW-1:0];
        if (state_reg == psr_pkg::ST_LOAD) begin
            mem_we = pipe_vld_reg;
            mem_waddr = pipe_addr_reg;
            mem_wdata = load_byte;
        end else if (state_reg == psr_pkg::ST_BURN) begin
            mem_raddr = cnt_reg;
        end else begin
            mem_we = host_wr;
        end
    end

    psr_mem #(.AW(MEM_AW), .DW(8)) u_mem (
        .i_mclk(i_mclk),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(mem_wdata),
        .i_raddr(mem_raddr),
        .o_rdata(mem_rdata)
    );

    // Sequencer: power-up load, hard reset reload, bank burn
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        pipe_vld_next = 1'b0;
        pipe_addr_next = cnt_reg;
        align_next = 1'b0;
        page_next = page_reg;
        pdn_next = pdn_reg;
        out_en_next = out_en_reg;
        io_cfg_next = io_cfg_reg;
        case (state_reg)
            psr_pkg::ST_LOAD: begin
                pipe_vld_next = 1'b1;
                if (cnt_reg != CNT_LAST) begin
                    cnt_next = cnt_reg + 1'b1;
                end else if (pipe_vld_reg && pipe_addr_reg == CNT_LAST) begin
                    pipe_vld_next = 1'b0;
                    state_next = psr_pkg::ST_RUN;
                    align_next = 1'b1;
                end
            end
            psr_pkg::ST_BURN: begin
                pipe_vld_next = 1'b1;
                if (cnt_reg != CNT_LAST) begin
                    cnt_next = cnt_reg + 1'b1;
                end else if (pipe_vld_reg && pipe_addr_reg == CNT_LAST) begin
                    pipe_vld_next = 1'b0;
                    state_next = psr_pkg::ST_RUN;
                end
            end
            psr_pkg::ST_RUN: begin
                cnt_next = '0;
                if (host_wr && i_req.offset == psr_pkg::OFS_PAGE) begin
                    page_next = i_req.wdata;
                end
                if (host_wr && addr == psr_pkg::ADDR_CTRL) begin
                    pdn_next = i_req.wdata[psr_pkg::BIT_PDN];
                end
                if (host_wr && addr == psr_pkg::ADDR_BURN && i_req.wdata[psr_pkg::BIT_BURN]) begin
                    state_next = psr_pkg::ST_BURN;
                end
            end
            default: begin
                state_next = psr_pkg::ST_LOAD;
            end
        endcase
        // Shadows follow every store write so the outputs match the store
        if (mem_we && full_addr(mem_waddr) == psr_pkg::ADDR_OUT_EN) begin
            out_en_next = mem_wdata;
        end
        if (mem_we && full_addr(mem_waddr) == psr_pkg::ADDR_IO_CFG) begin
            io_cfg_next = mem_wdata;
        end
        if (hard_rst_req) begin
            state_next = psr_pkg::ST_LOAD;
            cnt_next = '0;
            pipe_vld_next = 1'b0;
            page_next = psr_pkg::PAGE_RESET;
            pdn_next = 1'b0;
            // A reset landing on the last load cycle must not flag an aligned start
            align_next = 1'b0;
        end
    end

    // Read path: decode on the request, answer two edges later from a flop
    always_comb begin
        rd_pipe_next = {rd_pipe_reg[0], host_rd};
        rd_const_next = rd_const_reg;
        rd_use_mem_next = rd_use_mem_reg;
        rdata_next = rd_use_mem_reg ? mem_rdata : rd_const_reg;
        if (host_rd) begin
            rd_use_mem_next = 1'b0;
            rd_const_next = psr_pkg::BYTE_ZERO;
            if (i_req.offset == psr_pkg::OFS_PAGE) begin
                rd_const_next = page_reg;
            end else if (page_reg != psr_pkg::PAGE_RESET) begin
                rd_use_mem_next = 1'b1;
            end else begin
                case (i_req.offset)
                    psr_pkg::OFS_SIL_REV: rd_const_next = {4'h0, SIL_REV};
                    psr_pkg::OFS_PN_LO: rd_const_next = PART_NUM[7:0];
                    psr_pkg::OFS_PN_HI: rd_const_next = PART_NUM[15:8];
                    psr_pkg::OFS_GRADE: rd_const_next = GRADE;
                    psr_pkg::OFS_DEV_REV: rd_const_next = DEV_REV;
                    psr_pkg::ADDR_CTRL[7:0]: rd_const_next = {7'h00, pdn_reg};
                    psr_pkg::ADDR_BURN[7:0]: rd_const_next = psr_pkg::BYTE_ZERO;
                    default: rd_use_mem_next = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_reg <= psr_pkg::ST_LOAD;
            cnt_reg <= '0;
            pipe_vld_reg <= 1'b0;
            pipe_addr_reg <= '0;
            align_reg <= 1'b0;
            page_reg <= psr_pkg::PAGE_RESET;
            pdn_reg <= 1'b0;
            out_en_reg <= psr_pkg::BLANK_OUT_EN;
            io_cfg_reg <= psr_pkg::BLANK_IO_CFG;
            rd_pipe_reg <= '0;
            rd_const_reg <= psr_pkg::BYTE_ZERO;
            rd_use_mem_reg <= 1'b0;
            rdata_reg <= psr_pkg::BYTE_ZERO;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            pipe_vld_reg <= pipe_vld_next;
            pipe_addr_reg <= pipe_addr_next;
            align_reg <= align_next;
            page_reg <= page_next;
            pdn_reg <= pdn_next;
            out_en_reg <= out_en_next;
            io_cfg_reg <= io_cfg_next;
            rd_pipe_reg <= rd_pipe_next;
            rd_const_reg <= rd_const_next;
            rd_use_mem_reg <= rd_use_mem_next;
            rdata_reg <= rdata_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_rvalid = rd_pipe_reg[1];
    assign o_busy = (state_reg != psr_pkg::ST_RUN);
    assign o_nvm_addr = (state_reg == psr_pkg::ST_BURN) ? pipe_addr_reg : cnt_reg;
    assign o_nvm_we = (state_reg == psr_pkg::ST_BURN) && pipe_vld_reg;
    assign o_nvm_wdata = mem_rdata;
    assign o_cfg.out_en = out_en_reg;
    assign o_cfg.io_1v8 = io_cfg_reg[psr_pkg::BIT_IO_1V8];
    assign o_cfg.ref_ext_osc = io_cfg_reg[psr_pkg::BIT_REF_EXT_OSC];
    assign o_cfg.powerdown = pdn_reg;
    // Clocks stay off until a load finishes so they all start together
    assign o_out_clk_en = (o_busy || pdn_reg) ? psr_pkg::BYTE_ZERO : out_en_reg;
    assign o_align_pulse = align_reg;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    a_pin_reload: assert property (!i_hard_reset_pin_n |=> o_busy && page_reg == 8'h00)
        else $error("reset pin did not start a reload");
    a_bit_reload: assert property (host_wr && addr == 16'h001E && i_req.wdata[1] && i_hard_reset_pin_n
        |=> state_reg == psr_pkg::ST_LOAD && cnt_reg == '0)
        else $error("hard reset bit did not start a reload");
    a_align_end: assert property ($rose(o_align_pulse) |-> $past(state_reg) == psr_pkg::ST_LOAD
        && !o_busy)
        else $error("alignment pulse not at end of load");
    a_page_write: assert property (host_wr && i_req.offset == 8'h01 && i_hard_reset_pin_n
        && !(addr == 16'h001E && i_req.wdata[1]) |=> page_reg == $past(i_req.wdata))
        else $error("page write not taken");
    a_page_read: assert property (host_rd && i_req.offset == 8'h01 && i_hard_reset_pin_n
        |-> ##2 o_rvalid && o_rdata == $past(page_reg, 2))
        else $error("page read wrong");
    a_rev_read: assert property (host_rd && addr == 16'h0000 |-> ##2 o_rdata == {4'h0, SIL_REV})
        else $error("silicon revision read wrong");
    a_part_hi: assert property (host_rd && addr == 16'h0003 |-> ##2 o_rdata == PART_NUM[15:8])
        else $error("part number high byte wrong");
    a_grade_read: assert property (host_rd && addr == 16'h0004 |-> ##2 o_rdata == GRADE)
        else $error("grade read wrong");
    a_devrev_read: assert property (host_rd && addr == 16'h0005 |-> ##2 o_rdata == DEV_REV)
        else $error("device revision read wrong");
    a_blank_off: assert property (o_busy |-> o_out_clk_en == 8'h00)
        else $error("outputs enabled during load");
    a_blank_defaults: assert property (i_nvm_blank && o_align_pulse |-> o_cfg.out_en == 8'h00
        && o_cfg.io_1v8 && o_cfg.ref_ext_osc)
        else $error("blank part did not come up with its defaults");
    a_pdn_gate: assert property (pdn_reg |-> o_out_clk_en == 8'h00 && !o_cfg.powerdown == 1'b0)
        else $error("powerdown did not gate outputs");
    a_burn_start: assert property (host_wr && addr == 16'h0022 && i_req.wdata[0] && i_hard_reset_pin_n
        && !(addr == 16'h001E) |=> state_reg == psr_pkg::ST_BURN ##1 o_nvm_we)
        else $error("burn did not start");
    a_addr_form: assert property (mem_we && state_reg == psr_pkg::ST_RUN
        |-> mem_waddr == MEM_AW'({page_reg, i_req.offset}))
        else $error("address not formed from page and offset");

    c_page_change: cover property (host_wr && i_req.offset == 8'h01 ##1 host_rd);
    // Loads and burns outlast any sensible delay range, so their ends are covered by state
    c_hard_reset: cover property ($rose(i_hard_reset_pin_n) ##1 o_busy);
    c_reload_done: cover property (o_align_pulse && !i_nvm_blank);
    c_burn_done: cover property ($past(state_reg) == psr_pkg::ST_BURN && !o_busy);
endmodule : psr_regs

// ===== tb/psr_nvm_model.sv
// Non-volatile byte store model facing the register bank
module psr_nvm_model #(
    parameter int AW = 10
) (
    input wire logic i_mclk,            // System clock
    input wire logic [AW-1:0] i_addr,   // Store address
    input wire logic i_we,              // Write pulse
    input wire logic [7:0] i_wdata,     // Write data
    output logic [7:0] o_data           // Read data, one cycle after address
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [2**AW];
    // Preloaded with a non-trivial pattern so a missed burn cannot read back as written
    initial begin
        for (int i = 0; i < 2**AW; i++) begin
            mem[i] = 8'hC3 ^ i[7:0];
        end
        o_data = 8'h00;
    end
    always @(posedge i_mclk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_data <= mem[i_addr];
    end
endmodule : psr_nvm_model

// ===== tb/psr_regs_tb_top.sv
// Self-checking bench for the page-select and identification register bank
module psr_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int AW = 10;
    localparam logic [3:0] T_SIL = 4'h9;     // Arbitrary value
    localparam logic [15:0] T_PN = 16'h3C7E; // Arbitrary value
    localparam logic [7:0] T_GRADE = 8'h01;  // Arbitrary value
    localparam logic [7:0] T_DREV = 8'h06;   // Arbitrary value
    logic mclk, rst, hard_reset_pin_n, nvm_blank;
    psr_pkg::psr_req_type req;
    logic [7:0] rdata, nvm_data, nvm_wdata, out_clk_en, rd_val;
    logic rvalid, busy, nvm_we, align_pulse;
    logic [AW-1:0] nvm_addr;
    psr_pkg::psr_cfg_type cfg;
    int n_errors = 0;
    int check_count = 0;
    int align_n = 0;
    int cycles = 0;

    psr_regs #(.MEM_AW(AW), .SIL_REV(T_SIL), .PART_NUM(T_PN), .GRADE(T_GRADE),
        .DEV_REV(T_DREV)) uut (.i_mclk(mclk), .i_rst(rst),
        .i_hard_reset_pin_n(hard_reset_pin_n), .i_req(req), .o_rdata(rdata),
        .o_rvalid(rvalid), .o_busy(busy), .i_nvm_blank(nvm_blank), .o_nvm_addr(nvm_addr),
        .i_nvm_data(nvm_data), .o_nvm_we(nvm_we), .o_nvm_wdata(nvm_wdata), .o_cfg(cfg),
        .o_out_clk_en(out_clk_en), .o_align_pulse(align_pulse));
    psr_nvm_model #(.AW(AW)) nvm (.i_mclk(mclk), .i_addr(nvm_addr), .i_we(nvm_we),
        .i_wdata(nvm_wdata), .o_data(nvm_data));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (align_pulse === 1'b1) begin
            align_n <= align_n + 1;
        end
    end
    // Whole run needs about four loads or burns of 1025 cycles each
    always @(negedge mclk) begin
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] ofs, input logic [7:0] data);
        @(negedge mclk);
        req = '{wr: 1'b1, rd: 1'b0, offset: ofs, wdata: data};
        @(negedge mclk);
        req.wr = 1'b0;
    endtask : wr

    // Answer is due exactly one edge after the taking edge
    task automatic rd(input logic [7:0] ofs, output logic [7:0] data);
        @(negedge mclk);
        req = '{wr: 1'b0, rd: 1'b1, offset: ofs, wdata: 8'h00};
        @(negedge mclk);
        req.rd = 1'b0;
        @(negedge mclk);
        check({15'h0000, rvalid}, 16'h0001);
        data = rdata;
    endtask : rd

    task automatic wait_idle(input int exp_align);
        int n;
        int a0;
        a0 = align_n;
        n = 0;
        repeat (2) @(negedge mclk);
        while (busy !== 1'b0 && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        // The pulse rises with busy falling and is counted one edge later
        @(negedge mclk);
        check(16'(align_n - a0), 16'(exp_align));
    endtask : wait_idle

    task automatic t_blank();
        check({8'h00, cfg.out_en}, 16'h0000);
        check({8'h00, out_clk_en}, 16'h0000);
        check({14'h0000, cfg.io_1v8, cfg.ref_ext_osc}, 16'h0003);
        rd(8'h00, rd_val);
        check({12'h000, rd_val[3:0]}, {12'h000, T_SIL});
        wr(8'h02, 8'hFF);
        rd(8'h02, rd_val);
        check({8'h00, rd_val}, {8'h00, T_PN[7:0]});
        rd(8'h03, rd_val);
        check({8'h00, rd_val}, {8'h00, T_PN[15:8]});
        rd(8'h04, rd_val);
        check({8'h00, rd_val}, {8'h00, T_GRADE});
        rd(8'h05, rd_val);
        check({8'h00, rd_val}, {8'h00, T_DREV});
    endtask : t_blank

    task automatic t_page();
        logic [7:0] pages [3] = '{8'h01, 8'hFF, 8'h02};
        rd(8'h01, rd_val);
        check({8'h00, rd_val}, 16'h0000);
        foreach (pages[i]) begin
            wr(8'h01, pages[i]);
            rd(8'h01, rd_val);
            check({8'h00, rd_val}, {8'h00, pages[i]});
        end
        // Same offset on two pages must land in two different places
        wr(8'h01, 8'h01);
        wr(8'h10, 8'hAB);
        wr(8'h01, 8'h02);
        wr(8'h10, 8'hCD);
        wr(8'h01, 8'h01);
        rd(8'h10, rd_val);
        check({8'h00, rd_val}, 16'h00AB);
        wr(8'h01, 8'h00);
    endtask : t_page

    task automatic t_burn_reload();
        wr(8'h20, 8'h5A);
        @(negedge mclk);
        check({8'h00, out_clk_en}, 16'h005A);
        wr(8'h22, 8'h01);
        wait_idle(0);
        nvm_blank = 1'b0;
        wr(8'h01, 8'h01);
        wr(8'h10, 8'h11);
        wr(8'h01, 8'h00);
        wr(8'h1E, 8'h02);
        @(negedge mclk);
        check({15'h0000, busy}, 16'h0001);
        check({8'h00, out_clk_en}, 16'h0000);
        wait_idle(1);
        check({8'h00, cfg.out_en}, 16'h005A);
        rd(8'h01, rd_val);
        check({8'h00, rd_val}, 16'h0000);
        wr(8'h01, 8'h01);
        rd(8'h10, rd_val);
        check({8'h00, rd_val}, 16'h00AB);
    endtask : t_burn_reload

    task automatic t_pin();
        wr(8'h01, 8'h03);
        hard_reset_pin_n = 1'b0;
        repeat (2) @(negedge mclk);
        hard_reset_pin_n = 1'b1;
        wait_idle(1);
        rd(8'h01, rd_val);
        check({8'h00, rd_val}, 16'h0000);
        check({8'h00, out_clk_en}, 16'h005A);
    endtask : t_pin

    task automatic t_pdn();
        wr(8'h1E, 8'h01);
        @(negedge mclk);
        check({15'h0000, cfg.powerdown}, 16'h0001);
        check({8'h00, out_clk_en}, 16'h0000);
        rd(8'h20, rd_val);
        check({8'h00, rd_val}, 16'h005A);
        wr(8'h1E, 8'h00);
        @(negedge mclk);
        check({8'h00, out_clk_en}, 16'h005A);
    endtask : t_pdn

    initial begin
        rst = 1'b1;
        hard_reset_pin_n = 1'b1;
        nvm_blank = 1'b1;
        req = '{wr: 1'b0, rd: 1'b0, offset: 8'h00, wdata: 8'h00};
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        wait_idle(1);
        t_blank();
        t_page();
        t_burn_reload();
        t_pin();
        t_pdn();
        summarize();
    end
endmodule : psr_regs_tb_top
